// *** src/cetb_pkg.sv ***
// Constants, register map and state type for the CAN error-state and transmit-buffer block.
// Assumes one 50 MHz clock domain and an 8-bit APB byte address.
package cetb_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_TX_BUF = 3;

    // Register byte addresses, one aligned word each
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL_BASE = 8'h10;
    localparam logic [7:0] ADDR_IDH_BASE = 8'h20;
    localparam logic [7:0] ADDR_IDL_BASE = 8'h30;
    localparam logic [7:0] ADDR_STRIDE = 8'h04;

    // Operating modes
    localparam logic [1:0] MODE_LEGACY = 2'h0;
    localparam logic [1:0] MODE_ENHANCED = 2'h1;
    localparam logic [1:0] MODE_FIFO = 2'h2;

    // Status bit positions
    localparam int ST_TOP_BIT = 7;
    localparam int ST_OVFL_BIT = 6;
    localparam int ST_BUSOFF_BIT = 5;
    localparam int ST_TXPASS_BIT = 4;
    localparam int ST_RXPASS_BIT = 3;
    localparam int ST_TX_WARNING_BIT = 2;
    localparam int ST_RX_WARNING_BIT = 1;
    localparam int ST_ANYWARN_BIT = 0;

    // Buffer control bit positions
    localparam int CT_DONE_BIT = 7;
    localparam int CT_ABORT_BIT = 6;
    localparam int CT_LARB_BIT = 5;
    localparam int CT_BERR_BIT = 4;
    localparam int CT_REQ_BIT = 3;

    // Identifier low byte: implemented bits and extended select position
    localparam logic [7:0] IDL_MASK = 8'heb;
    localparam int IDL_EXT_BIT = 3;

    // Error count thresholds
    localparam logic [8:0] BUSOFF_LIMIT = 9'h0ff;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
    localparam logic [8:0] WARN_LIMIT = 9'h05f;

    // Recessive-run events needed to leave bus-off
    localparam int RECOVERY_EVENTS = 128;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Whole state of the block
    typedef struct packed {
        logic ov0;
        logic ov1;
        logic [5:0] errFlags;
        logic [2:0] doneFlag;
        logic [2:0] aborted;
        logic [2:0] lostArb;
        logic [2:0] busErr;
        logic [2:0] request;
        logic [2:0] abortPend;
        logic [2:0][1:0] prio;
        logic [2:0][7:0] identHigh;
        logic [2:0][7:0] identLow;
        logic [7:0] recovCount;
        logic countClear;
        logic [1:0] selBuf;
        logic selValid;
        logic [7:0] selIdentHigh;
        logic selExt;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } cetb_state_t;

    // Address of buffer slot i above a base
    function automatic logic [7:0] slotAddr(input logic [7:0] base, input int i);
        return base + 8'(i * 4);
    endfunction

endpackage

// *** src/cetb_ctrl.sv ***
// Error-state flags and three transmit buffers of a CAN controller, reached over APB.
// Assumes error counts, overflow and transmit events come from a protocol engine
// on the same clock; operating mode comes from the mode configuration.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module cetb_ctrl #(
    parameter int RecoveryCount = cetb_pkg::RECOVERY_EVENTS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave
    input wire logic [cetb_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cetb_pkg::DATA_W-1:0] pwdata,
    output logic [cetb_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Mode configuration and error counts
    input wire logic [1:0] opMode,
    input wire logic [8:0] txErrCount,
    input wire logic [8:0] rxErrCount,
    // Receive side events and state
    input wire logic rxBuf0Overflow,
    input wire logic rxBuf1Overflow,
    input wire logic rxAnyBufOverflow,
    input wire logic rxFifoNotEmpty,
    // Transmit events from the protocol engine, one bit per buffer, and the recessive-run event
    input wire logic [2:0] txSent,
    input wire logic [2:0] txAbortDone,
    input wire logic [2:0] txArbLost,
    input wire logic [2:0] txBusErrorSeen,
    input wire logic recessiveRun,
    // Requests toward the protocol engine
    output logic [2:0] txRequest,
    output logic [2:0] txAbortReq,
    output logic [1:0] txSelBuf,
    output logic txSelValid,
    output logic [7:0] txSelIdentHigh,
    output logic txSelExtSelect,
    output logic txErrCountClear
);
    import cetb_pkg::*;

    // Refuse a recovery count the 8-bit counter cannot hold
    if (RecoveryCount < 1 || RecoveryCount > 255) begin : gBadCount
        $error("RecoveryCount must lie in 1..255");
    end

    localparam logic [7:0] RECOV_LAST = 8'(RecoveryCount - 1);

    cetb_state_t s;
    cetb_state_t next_s;
    logic wrEn;
    logic rdPhase;
    logic hit;
    logic [7:0] rdData;
    logic found;
    logic [1:0] bestPrio;
    logic [1:0] bestIdx;

    // Next state of the whole block
    always_comb begin
        next_s = s;
        next_s.countClear = 1'b0;
        wrEn = psel & penable & s.pready & pwrite;
        rdPhase = psel & penable & ~s.pready;

        // Error-state flags from the counts each cycle
        next_s.errFlags[ST_BUSOFF_BIT] = txErrCount > BUSOFF_LIMIT;
        next_s.errFlags[ST_TXPASS_BIT] = txErrCount > PASSIVE_LIMIT;
        next_s.errFlags[ST_RXPASS_BIT] = rxErrCount > PASSIVE_LIMIT;
        next_s.errFlags[ST_TX_WARNING_BIT] = txErrCount > WARN_LIMIT;
        next_s.errFlags[ST_RX_WARNING_BIT] = (rxErrCount > WARN_LIMIT) &&
            (rxErrCount <= PASSIVE_LIMIT);
        next_s.errFlags[ST_ANYWARN_BIT] = next_s.errFlags[ST_RX_WARNING_BIT] |
            next_s.errFlags[ST_TX_WARNING_BIT];

        // Overflow bits: software writes zero to clear, a new event wins
        if (wrEn && paddr == ADDR_STATUS) begin
            if (!pwdata[ST_TOP_BIT]) begin
                next_s.ov0 = 1'b0;
            end
            if (!pwdata[ST_OVFL_BIT]) begin
                next_s.ov1 = 1'b0;
            end
        end
        if (opMode == MODE_LEGACY && rxBuf0Overflow) begin
            next_s.ov0 = 1'b1;
        end
        if (opMode == MODE_LEGACY ? rxBuf1Overflow : rxAnyBufOverflow) begin
            next_s.ov1 = 1'b1;
        end

        // Per-buffer software writes and engine events
        for (int i = 0; i < NUM_TX_BUF; i++) begin
            if (wrEn && paddr == slotAddr(ADDR_CTRL_BASE, i)) begin
                if (!pwdata[CT_DONE_BIT]) begin
                    next_s.doneFlag[i] = 1'b0;
                end
                if (pwdata[CT_REQ_BIT] && !s.request[i]) begin
                    next_s.request[i] = 1'b1;
                    next_s.aborted[i] = 1'b0;
                    next_s.lostArb[i] = 1'b0;
                    next_s.busErr[i] = 1'b0;
                end else if (!pwdata[CT_REQ_BIT] && s.request[i]) begin
                    next_s.abortPend[i] = 1'b1;
                end
                if (!s.request[i]) begin
                    next_s.prio[i] = pwdata[1:0];
                end
            end
            if (wrEn && paddr == slotAddr(ADDR_IDH_BASE, i) && !s.request[i]) begin
                next_s.identHigh[i] = pwdata[7:0];
            end
            if (wrEn && paddr == slotAddr(ADDR_IDL_BASE, i) && !s.request[i]) begin
                next_s.identLow[i] = pwdata[7:0] & IDL_MASK;
            end
            if (s.request[i]) begin
                if (txArbLost[i]) begin
                    next_s.lostArb[i] = 1'b1;
                end
                if (txBusErrorSeen[i]) begin
                    next_s.busErr[i] = 1'b1;
                end
                if (txSent[i]) begin
                    next_s.request[i] = 1'b0;
                    next_s.abortPend[i] = 1'b0;
                    next_s.doneFlag[i] = 1'b1;
                end else if (txAbortDone[i]) begin
                    next_s.request[i] = 1'b0;
                    next_s.abortPend[i] = 1'b0;
                    next_s.aborted[i] = 1'b1;
                end
            end
        end

        // Highest priority pending buffer, higher index wins a tie
        found = 1'b0;
        bestPrio = 2'h0;
        bestIdx = 2'h0;
        for (int i = 0; i < NUM_TX_BUF; i++) begin
            if (s.request[i] && !s.abortPend[i] && (!found || s.prio[i] >= bestPrio)) begin
                found = 1'b1;
                bestPrio = s.prio[i];
                bestIdx = 2'(i);
            end
        end
        next_s.selValid = found;
        next_s.selBuf = bestIdx;
        next_s.selIdentHigh = s.identHigh[bestIdx];
        next_s.selExt = s.identLow[bestIdx][IDL_EXT_BIT];

        // Bus-off recovery: count recessive runs while off
        if (!s.errFlags[ST_BUSOFF_BIT]) begin
            next_s.recovCount = 8'h00;
        end else if (recessiveRun) begin
            if (s.recovCount == RECOV_LAST) begin
                next_s.recovCount = 8'h00;
                next_s.countClear = 1'b1;
            end else begin
                next_s.recovCount = s.recovCount + 8'h01;
            end
        end

        // Read decode
        hit = 1'b0;
        rdData = RESET_BYTE;
        if (paddr == ADDR_STATUS) begin
            hit = 1'b1;
            rdData = {1'b0, s.ov1, s.errFlags};
            case (opMode)
                MODE_LEGACY: rdData[ST_TOP_BIT] = s.ov0;
                MODE_ENHANCED: rdData[ST_TOP_BIT] = 1'b0;
                default: rdData[ST_TOP_BIT] = rxFifoNotEmpty;
            endcase
        end
        for (int i = 0; i < NUM_TX_BUF; i++) begin
            if (paddr == slotAddr(ADDR_CTRL_BASE, i)) begin
                hit = 1'b1;
                rdData = {s.doneFlag[i], s.aborted[i], s.lostArb[i], s.busErr[i],
                    s.request[i], 1'b0, s.prio[i]};
            end
            if (paddr == slotAddr(ADDR_IDH_BASE, i)) begin
                hit = 1'b1;
                rdData = s.identHigh[i];
            end
            if (paddr == slotAddr(ADDR_IDL_BASE, i)) begin
                hit = 1'b1;
                rdData = s.identLow[i];
            end
        end

        // APB answer one cycle into the access phase
        next_s.pready = rdPhase;
        next_s.pslverr = rdPhase & ~hit;
        next_s.prdata = (rdPhase && !pwrite && hit) ? {24'h000000, rdData} : RESET_WORD;
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign txRequest = s.request;
    assign txAbortReq = s.abortPend;
    assign txSelBuf = s.selBuf;
    assign txSelValid = s.selValid;
    assign txSelIdentHigh = s.selIdentHigh;
    assign txSelExtSelect = s.selExt;
    assign txErrCountClear = s.countClear;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // Access-phase decodes and overflow events seen by the checks
    logic statusRead;
    logic statusWrite;
    logic ov0Event;
    logic ov1Event;
    assign statusRead = psel & penable & ~s.pready & ~pwrite & (paddr == ADDR_STATUS);
    assign statusWrite = psel & penable & s.pready & pwrite & (paddr == ADDR_STATUS);
    assign ov0Event = (opMode == MODE_LEGACY) & rxBuf0Overflow;
    assign ov1Event = (opMode == MODE_LEGACY) ? rxBuf1Overflow : rxAnyBufOverflow;

    // A status read answered one cycle into the access phase
    sequence statusAnswer;
        statusRead ##1 pready;
    endsequence

    // Error-state flags one cycle behind the counts
    busoff_flag_a: assert property (
        ##1 s.errFlags[ST_BUSOFF_BIT] == ($past(txErrCount) > 9'h0ff))
        else $error("bus-off flag wrong");
    tx_passive_a: assert property (
        ##1 s.errFlags[ST_TXPASS_BIT] == ($past(txErrCount) > 9'h07f))
        else $error("transmit passive wrong");
    rx_passive_a: assert property (
        ##1 s.errFlags[ST_RXPASS_BIT] == ($past(rxErrCount) > 9'h07f))
        else $error("receive passive wrong");
    tx_warn_a: assert property (
        ##1 s.errFlags[ST_TX_WARNING_BIT] == ($past(txErrCount) > 9'h05f))
        else $error("transmit warning wrong");
    rx_warn_a: assert property (
        (rxErrCount > 9'h07f) |=> !s.errFlags[ST_RX_WARNING_BIT])
        else $error("receive warning above passive");
    rx_warn_band_a: assert property (
        ##1 s.errFlags[ST_RX_WARNING_BIT] ==
        ($past(rxErrCount) > 9'h05f && $past(rxErrCount) <= 9'h07f))
        else $error("receive warning outside its band");
    any_warn_a: assert property (
        s.errFlags[ST_ANYWARN_BIT] == (s.errFlags[ST_RX_WARNING_BIT] | s.errFlags[ST_TX_WARNING_BIT]))
        else $error("any warning not OR");

    // Top status bit per operating mode
    mode0_top_a: assert property (
        (statusRead && opMode == MODE_LEGACY) |=> prdata[ST_TOP_BIT] == $past(s.ov0))
        else $error("overflow bit wrong in mode 0");
    mode1_top_a: assert property (
        (statusRead && opMode == MODE_ENHANCED) |=> !prdata[ST_TOP_BIT])
        else $error("top bit set in mode 1");
    mode2_top_a: assert property (
        (statusRead && opMode == MODE_FIFO) |=> prdata[ST_TOP_BIT] == $past(rxFifoNotEmpty))
        else $error("fifo bit wrong");
    status_upper_a: assert property (
        statusAnswer |-> prdata[31:8] == 24'h000000 && !pslverr)
        else $error("status answer malformed");

    // Sticky overflow bits: events set, software zero clears
    ov0_set_a: assert property (
        ov0Event |=> s.ov0)
        else $error("buffer zero overflow lost");
    ov1_set_a: assert property (
        ov1Event |=> s.ov1)
        else $error("second overflow bit lost");
    ov1_keep_a: assert property (
        (s.ov1 && !statusWrite) |=> s.ov1)
        else $error("overflow bit dropped without a write");
    ov1_clear_a: assert property (
        (statusWrite && !pwdata[ST_OVFL_BIT] && !ov1Event) |=> !s.ov1)
        else $error("overflow bit not cleared");

    // Bus answer stands a single cycle
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready held too long");

    // Recovery pulse only from a recessive run while bus-off
    recov_clear_a: assert property (
        txErrCountClear |-> $past(s.errFlags[ST_BUSOFF_BIT] && recessiveRun))
        else $error("count clear without recovery");

    for (genvar g = 0; g < NUM_TX_BUF; g++) begin : gChk
        logic ctrlWrite;
        logic ctrlRead;
        assign ctrlWrite = psel & penable & s.pready & pwrite &
            (paddr == slotAddr(ADDR_CTRL_BASE, g));
        assign ctrlRead = psel & penable & ~s.pready & ~pwrite &
            (paddr == slotAddr(ADDR_CTRL_BASE, g));
        sequence reqSetWrite;
            ctrlWrite && pwdata[CT_REQ_BIT] && !s.request[g];
        endsequence
        sequence sentWhilePending;
            s.request[g] && txSent[g];
        endsequence
        sequence ctrlAnswer;
            ctrlRead ##1 pready;
        endsequence
        req_clears_a: assert property (
            reqSetWrite |=> s.request[g] && !s.aborted[g] && !s.lostArb[g] && !s.busErr[g])
            else $error("request set did not clear status");
        sent_done_a: assert property (
            sentWhilePending |=> !s.request[g] && s.doneFlag[g])
            else $error("sent message not retired");
        ident_lock_a: assert property (
            s.request[g] |=> s.identHigh[g] == $past(s.identHigh[g]))
            else $error("ident changed while pending");
        ident_low_lock_a: assert property (
            s.request[g] |=> s.identLow[g] == $past(s.identLow[g]))
            else $error("ident low byte changed while pending");
        prio_lock_a: assert property (
            s.request[g] |=> s.prio[g] == $past(s.prio[g]))
            else $error("priority changed while pending");
        abort_req_a: assert property (
            (ctrlWrite && !pwdata[CT_REQ_BIT] && s.request[g] && !txSent[g] && !txAbortDone[g])
            |=> s.abortPend[g] && s.request[g])
            else $error("abort not requested");
        abort_done_a: assert property (
            (s.request[g] && !txSent[g] && txAbortDone[g]) |=> s.aborted[g] && !s.request[g])
            else $error("abort not recorded");
        lost_arb_a: assert property (
            (s.request[g] && txArbLost[g]) |=> s.lostArb[g])
            else $error("lost arbitration not recorded");
        bus_err_a: assert property (
            (s.request[g] && txBusErrorSeen[g]) |=> s.busErr[g])
            else $error("bus error not recorded");
        done_keep_a: assert property (
            (s.doneFlag[g] && !(ctrlWrite && !pwdata[CT_DONE_BIT])) |=> s.doneFlag[g])
            else $error("done flag dropped without a clear");
        ctrl_bit2_a: assert property (
            ctrlAnswer |-> !prdata[2])
            else $error("control bit 2 not zero");
        sel_pending_a: assert property (
            (s.request[g] && !s.abortPend[g]) |=> txSelValid)
            else $error("pending buffer not offered");
    end

endmodule

// *** tb/cetb_engine_model.sv ***
// Behavioural protocol engine standing in for the CAN bus side of the block.
// Assumes the bench pulses cmdGo for one cycle to resolve the offered buffer.
`timescale 1ns/10ps
module cetb_engine_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // What the block offers
    input wire logic [2:0] txAbortReq,
    input wire logic [1:0] txSelBuf,
    input wire logic txSelValid,
    // Bench command: 1 sent, 2 arbitration lost, 3 bus error
    input wire logic [1:0] cmd,
    input wire logic cmdGo,
    input wire logic abortHold,
    // Events back to the block
    output logic [2:0] txSent,
    output logic [2:0] txAbortDone,
    output logic [2:0] txArbLost,
    output logic [2:0] txBusErrorSeen
);
    logic [2:0] hit;
    // Only the buffer on offer can be resolved
    assign hit = (cmdGo && txSelValid) ? 3'(3'h1 << txSelBuf) : 3'h0;
    // One-cycle outcome pulses
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            txSent <= 3'h0;
            txAbortDone <= 3'h0;
            txArbLost <= 3'h0;
            txBusErrorSeen <= 3'h0;
        end else begin
            txSent <= (cmd == 2'h1) ? hit : 3'h0;
            txArbLost <= (cmd == 2'h2) ? hit : 3'h0;
            txBusErrorSeen <= (cmd == 2'h3) ? hit : 3'h0;
            // Abort answered once; held back for a slow answer
            txAbortDone <= abortHold ? 3'h0 : (txAbortReq & ~txAbortDone);
        end
    end
endmodule

// *** tb/can_error_status_tx_buffer_ctrl_test.sv ***
// Self-checking bench for the error-state and transmit-buffer block over APB.
// Assumes one 50 MHz clock and the engine model on the far side.
`timescale 1ns/10ps
module can_error_status_tx_buffer_ctrl_test;
    import cetb_pkg::*;
    localparam logic [7:0] CT1 = 8'h14;
    localparam logic [7:0] CT2 = 8'h18;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] opMode = 2'h0;
    logic [8:0] txErrCount = 9'h000;
    logic [8:0] rxErrCount = 9'h000;
    logic [2:0] ovEv = 3'h0;
    logic rxFifoNotEmpty = 1'b0;
    logic recessiveRun = 1'b0;
    logic [1:0] cmd = 2'h0;
    logic cmdGo = 1'b0;
    logic abortHold = 1'b0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, txSelValid, txSelExtSelect, txErrCountClear;
    logic [2:0] txSent, txAbortDone, txArbLost, txBusErrorSeen, txRequest, txAbortReq;
    logic [1:0] txSelBuf;
    logic [7:0] txSelIdentHigh;
    int n_fail = 0;
    int n_tests = 0;
    int nClr = 0;
    // Count pairs and the status bits they give
    logic [8:0] tTx [8] = '{9'h0, 9'h5f, 9'h60, 9'h0, 9'h7f, 9'h80, 9'hff, 9'h100};
    logic [8:0] tRx [8] = '{9'h0, 9'h5f, 9'h0, 9'h60, 9'h7f, 9'h80, 9'h0, 9'h0};
    logic [7:0] tExp [8] = '{8'h0, 8'h0, 8'h05, 8'h03, 8'h07, 8'h1d, 8'h15, 8'h35};

    cetb_ctrl #(.RecoveryCount(4)) DUT (.clk_sys, .rst_b, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .opMode, .txErrCount, .rxErrCount,
        .rxBuf0Overflow(ovEv[0]), .rxBuf1Overflow(ovEv[1]), .rxAnyBufOverflow(ovEv[2]),
        .rxFifoNotEmpty, .txSent, .txAbortDone, .txArbLost, .txBusErrorSeen, .recessiveRun,
        .txRequest, .txAbortReq, .txSelBuf, .txSelValid, .txSelIdentHigh, .txSelExtSelect,
        .txErrCountClear);
    cetb_engine_model peer (.clk_sys, .rst_b, .txAbortReq, .txSelBuf, .txSelValid, .cmd,
        .cmdGo, .abortHold, .txSent, .txAbortDone, .txArbLost, .txBusErrorSeen);

    // 50 MHz clock
    initial forever #10 clk_sys = ~clk_sys;
    // Counts clear pulses
    always @(negedge clk_sys) begin
        if (txErrCountClear === 1'b1) nClr++;
    end

    task test_done;
        $display("mismatches %0d of %0d checks", n_fail, n_tests);
        if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chkData(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chkErr(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, bounded wait on pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        // Look at the answer where it has settled, act on the next edge
        do begin
            @(negedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            test_done;
        end
        rdata = prdata;
        rerr = pslverr;
        @(posedge clk_sys);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chkData(rdata, {24'h0, exp});
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task ov(input int i);
        @(posedge clk_sys);
        ovEv <= 3'h1 << i;
        @(posedge clk_sys);
        ovEv <= 3'h0;
    endtask
    task go(input logic [1:0] c);
        @(posedge clk_sys);
        cmd <= c;
        cmdGo <= 1'b1;
        @(posedge clk_sys);
        cmdGo <= 1'b0;
        idle(2);
    endtask
    task pulseRun;
        @(posedge clk_sys);
        recessiveRun <= 1'b1;
        @(posedge clk_sys);
        recessiveRun <= 1'b0;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(ADDR_STATUS, 8'h00);
        for (int i = 0; i < 3; i++) rd(ADDR_CTRL_BASE + 8'(4 * i), 8'h00);
        apb(1'b0, 8'h04, 32'h0);
        chkErr(rerr, 1'b1);
        chkData(rdata, 32'h0);
        // Flags follow the counts
        for (int i = 0; i < 8; i++) begin
            txErrCount <= tTx[i];
            rxErrCount <= tRx[i];
            rd(ADDR_STATUS, tExp[i]);
        end
        wr(ADDR_STATUS, 8'hff);
        rd(ADDR_STATUS, 8'h35);
        txErrCount <= 9'h000;
        // Overflow and FIFO bits per mode
        ov(0);
        rd(ADDR_STATUS, 8'h80);
        ov(2);
        rd(ADDR_STATUS, 8'h80);
        ov(1);
        rd(ADDR_STATUS, 8'hc0);
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        opMode <= MODE_ENHANCED;
        ov(0);
        ov(2);
        rd(ADDR_STATUS, 8'h40);
        wr(ADDR_STATUS, 8'h00);
        opMode <= MODE_FIFO;
        rxFifoNotEmpty <= 1'b1;
        rd(ADDR_STATUS, 8'h80);
        rxFifoNotEmpty <= 1'b0;
        rd(ADDR_STATUS, 8'h00);
        // Buffer 0: load, lock, send, clear done
        wr(ADDR_IDH_BASE, 8'ha5);
        rd(ADDR_IDH_BASE, 8'ha5);
        wr(ADDR_CTRL_BASE, 8'h0f);
        rd(ADDR_CTRL_BASE, 8'h0b);
        chkData({29'h0, txRequest}, 32'h1);
        wr(ADDR_IDH_BASE, 8'h5a);
        rd(ADDR_IDH_BASE, 8'ha5);
        go(2'h1);
        rd(ADDR_CTRL_BASE, 8'h83);
        wr(ADDR_CTRL_BASE, 8'h03);
        rd(ADDR_CTRL_BASE, 8'h03);
        // Buffer 1: losses, errors, slow abort, fresh request
        wr(CT1, 8'h08);
        go(2'h2);
        go(2'h3);
        rd(CT1, 8'h38);
        abortHold <= 1'b1;
        wr(CT1, 8'h00);
        @(negedge clk_sys);
        chkData({29'h0, txAbortReq}, 32'h2);
        rd(CT1, 8'h38);
        abortHold <= 1'b0;
        idle(3);
        rd(CT1, 8'h70);
        wr(CT1, 8'h08);
        rd(CT1, 8'h08);
        // Priority picks buffer 2, then buffer 0 once 2 is withdrawn
        wr(ADDR_IDH_BASE + 8'h08, 8'h3c);
        wr(ADDR_IDL_BASE + 8'h08, 8'h08);
        wr(ADDR_CTRL_BASE, 8'h09);
        wr(CT2, 8'h0b);
        idle(2);
        chkData({20'h0, txSelValid, txSelExtSelect, txSelIdentHigh, txSelBuf},
            {20'h0, 1'b1, 1'b1, 8'h3c, 2'h2});
        wr(CT2, 8'h00);
        idle(3);
        chkData({30'h0, txSelBuf}, 32'h0);
        // Bus-off recovery after the set number of recessive runs
        txErrCount <= 9'h100;
        repeat (3) pulseRun;
        idle(4);
        chkData(32'(nClr), 32'h0);
        pulseRun;
        idle(3);
        chkData(32'(nClr), 32'h1);
        test_done;
    end
endmodule
